// ### rtl/nvs_pkg.sv
// Package: timing constants and states for the nonvolatile memory host controller
package nvs_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ADDR_W        = 15;
    localparam int DATA_W        = 8;
    // Figures of the slowest speed grade, in ns; the lockout time in ms
    localparam int READ_CYCLE_MIN_NS        = 200;
    localparam int SELECT_ACCESS_MAX_NS     = 200;
    localparam int OE_ACCESS_MAX_NS         = 90;
    localparam int DESELECT_TO_FLOAT_MAX_NS = 70;
    localparam int WRITE_CYCLE_MIN_NS       = 200;
    localparam int SELECT_TO_END_MIN_NS     = 150;
    localparam int ADDR_TO_WRITE_END_MIN_NS = 150;
    localparam int WRITE_PULSE_MIN_NS       = 130;
    localparam int DATA_SETUP_MIN_NS        = 70;
    localparam int SELECT_RECOVERY_MIN_NS   = 15;
    localparam int SELECT_DATA_HOLD_MIN_NS  = 10;
    localparam int POWERUP_LOCKOUT_TIME_MS  = 120;
    // Least times round up to whole cycles
    localparam int READ_SAMPLE_CYC = (SELECT_ACCESS_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int FLOAT_CYC       = (DESELECT_TO_FLOAT_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_PULSE_CYC = (SELECT_TO_END_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC        = (SELECT_RECOVERY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCKOUT_CYC     = POWERUP_LOCKOUT_TIME_MS * 1000000 / (CLK_PERIOD_PS / 1000);
    localparam int CNT_W           = 25;
    typedef enum logic [2:0] {
        ST_LOCKOUT,
        ST_IDLE,
        ST_READ,
        ST_READ_FLOAT,
        ST_WRITE_SETUP,
        ST_WRITE_PULSE,
        ST_WRITE_HOLD
    } nvs_state_t;
endpackage

// ### rtl/nvs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module nvs_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] INIT    = '0
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    wire  [W-1:0] agree = ~(s2_q ^ s3_q);
    wire  [W-1:0] out_d = (agree & s2_q) | (~agree & dout);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            dout <= INIT;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            dout <= out_d;
        end
    end
endmodule
`default_nettype wire

// ### rtl/nvs_host.sv
// Host controller driving a battery-backed 32K x 8 asynchronous memory port
`timescale 1ns/1ps
`default_nettype none
module nvs_host
    import nvs_pkg::*;
#(
    parameter int LOCKOUT_CYCLES = LOCKOUT_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output var  logic              req_ready,
    output var  logic              rsp_valid,
    output var  logic [DATA_W-1:0] rsp_rdata,
    output var  logic              mem_ready,
    output var  logic [ADDR_W-1:0] mem_addr,
    output var  logic              mem_sel_n,
    output var  logic              mem_wstrobe_n,
    output var  logic              mem_oe_n,
    output var  logic [DATA_W-1:0] mem_dq_o,
    output var  logic              mem_dq_oe,
    input  wire logic [DATA_W-1:0] mem_dq_i
);
    import nvs_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Read hold covers access time plus the pin synchroniser delay
    localparam int SYNC_LAT      = 4;
    localparam int READ_HOLD_CYC = READ_SAMPLE_CYC + SYNC_LAT;

    if (LOCKOUT_CYCLES < 1 || LOCKOUT_CYCLES >= (1 << CNT_W)) begin
        $error("LOCKOUT_CYCLES out of range");
    end
    if (READ_HOLD_CYC >= (1 << CNT_W) || WRITE_CYCLE_CYC >= (1 << CNT_W)) begin
        $error("timing counts exceed counter width");
    end
    if (WRITE_PULSE_CYC < 1 || HOLD_CYC < 1 || FLOAT_CYC < 1) begin
        $error("timing counts must be at least one cycle");
    end

    // ************************************************************
    // State and counter
    // ************************************************************
    nvs_state_t        state_q;
    nvs_state_t        state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [CNT_W-1:0]  cyc_q;
    logic [CNT_W-1:0]  cyc_d;
    logic [DATA_W-1:0] dq_sync;

    // Pin data is asynchronous to core_clk
    nvs_sync #(.W(DATA_W), .INIT('0)) u_dq_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .din      (mem_dq_i),
        .dout     (dq_sync)
    );

    wire cnt_done  = (cnt_q == '0);
    // Whole-cycle counter enforces read and write cycle minimums
    wire cyc_done  = (cyc_q == '0);
    wire idle_take = (state_q == ST_IDLE) && req_valid;

    // ************************************************************
    // Next state
    // ************************************************************
    // Slowest grade figures are used, so every grade is served
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
        cyc_d   = cyc_done ? cyc_q : cyc_q - CNT_W'(1);
        case (state_q)
            ST_LOCKOUT: begin
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req_valid && cyc_done) begin
                    cyc_d = req_write ? CNT_W'(WRITE_CYCLE_CYC) : CNT_W'(READ_CYCLE_MIN_NS * 1000 / CLK_PERIOD_PS);
                    if (req_write) begin
                        state_d = ST_WRITE_SETUP;
                        cnt_d   = '0;
                    end else begin
                        state_d = ST_READ;
                        cnt_d   = CNT_W'(READ_HOLD_CYC);
                    end
                end
            end
            ST_READ: begin
                if (cnt_done) begin
                    state_d = ST_READ_FLOAT;
                    cnt_d   = CNT_W'(FLOAT_CYC);
                end
            end
            ST_READ_FLOAT: begin
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_WRITE_SETUP: begin
                state_d = ST_WRITE_PULSE;
                cnt_d   = CNT_W'(WRITE_PULSE_CYC);
            end
            ST_WRITE_PULSE: begin
                if (cnt_done) begin
                    state_d = ST_WRITE_HOLD;
                    cnt_d   = CNT_W'(HOLD_CYC);
                end
            end
            ST_WRITE_HOLD: begin
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_LOCKOUT;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_LOCKOUT;
            cnt_q   <= CNT_W'(LOCKOUT_CYCLES);
            cyc_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            cyc_q   <= cyc_d;
        end
    end

    // ************************************************************
    // Pin drive, all registered
    // ************************************************************
    // One request in flight at a time; reads and writes never overlap
    wire in_write  = (state_d == ST_WRITE_SETUP) || (state_d == ST_WRITE_PULSE) || (state_d == ST_WRITE_HOLD);
    wire sel_d     = (state_d == ST_READ) || (state_d == ST_WRITE_PULSE);
    // Strobe falls with select and rises with it; oe stays high in writes
    wire strobe_d  = (state_d == ST_WRITE_PULSE);
    wire oe_d      = (state_d == ST_READ);
    // Data driven through setup, pulse and hold so it outlives the select rise
    wire dq_oe_d   = in_write;
    wire take_q    = idle_take && cyc_done;
    wire rd_done   = (state_q == ST_READ) && cnt_done;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_addr      <= '0;
            mem_sel_n     <= 1'b1;
            mem_wstrobe_n <= 1'b1;
            mem_oe_n      <= 1'b1;
            mem_dq_o      <= '0;
            mem_dq_oe     <= 1'b0;
            req_ready     <= 1'b0;
            mem_ready     <= 1'b0;
        end else begin
            if (take_q) begin
                mem_addr <= req_addr;
                mem_dq_o <= req_wdata;
            end
            mem_sel_n     <= ~sel_d;
            mem_wstrobe_n <= ~strobe_d;
            mem_oe_n      <= ~oe_d;
            mem_dq_oe     <= dq_oe_d;
            req_ready     <= (state_d == ST_IDLE) && (cyc_d == '0) && !take_q;
            mem_ready     <= (state_d != ST_LOCKOUT);
        end
    end

    // ************************************************************
    // Read response
    // ************************************************************
    // The byte is taken only after the synchroniser has settled on it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= rd_done;
            if (rd_done) begin
                rsp_rdata <= dq_sync;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/nvs_mem_model.sv
// Behavioural model of the battery-backed byte-wide memory
`timescale 1ns/1ps
`default_nettype none
module nvs_mem_model #(
    parameter int ACC_NS = 200
) (
    input  wire logic [14:0] addr,
    input  wire logic        sel_n,
    input  wire logic        wstrobe_n,
    input  wire logic        oe_n,
    input  wire logic [7:0]  din,
    output var  logic [7:0]  dout
);
    // ****************
    // Storage and pins
    // ****************
    logic [7:0] mem [0:32767];
    wire        rd_w = !sel_n && wstrobe_n && !oe_n;
    wire        wr_w = !sel_n && !wstrobe_n;
    // Contents count as retained from first power-up; no supply loss modelled
    initial dout = 8'h69;
    always @(negedge wr_w) mem[addr] <= din;
    // Released pins show the inverted byte 5 ns on, and each address change flips it back, so a late sample can see stale data
    always @(rd_w or addr) begin
        if (rd_w)
            dout <= #(ACC_NS) mem[addr];
        else
            dout <= #5 ~dout;
    end
endmodule
`default_nettype wire

// ### dv/nvs_host_sva.sv
// Concurrent checks on the memory host controller pins
`timescale 1ns/1ps
`default_nettype none
module nvs_host_sva
    import nvs_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              srst,
    input wire logic              mem_ready,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              mem_sel_n,
    input wire logic              mem_wstrobe_n,
    input wire logic              mem_oe_n,
    input wire logic [DATA_W-1:0] mem_dq_o,
    input wire logic              mem_dq_oe
);
    // ************
    // Pin protocol
    // ************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    host_quiet_a: assert property (mem_dq_oe |-> mem_oe_n) else $error("host drives in read");
    lock_idle_a: assert property (!mem_ready |-> mem_sel_n && mem_wstrobe_n) else $error("strobe in lockout");
    pulse_len_a: assert property ($fell(mem_wstrobe_n) |-> !mem_sel_n ##29 !mem_wstrobe_n && !mem_sel_n)
        else $error("write pulse short");
    data_hold_a: assert property ($rose(mem_wstrobe_n) |-> (mem_dq_oe && $stable(mem_dq_o))[*3])
        else $error("write data hold short");
    data_setup_a: assert property ($rose(mem_wstrobe_n) |-> $past(mem_dq_oe, 15))
        else $error("write data setup short");
    addr_stable_a: assert property (!mem_sel_n && !$past(mem_sel_n) |-> $stable(mem_addr))
        else $error("address moved while selected");
    read_len_a: assert property ($fell(mem_oe_n) |-> !mem_sel_n ##40 !mem_oe_n && !mem_sel_n)
        else $error("read access short");
    float_gap_a: assert property ($rose(mem_oe_n) |-> !mem_dq_oe[*8]) else $error("drive after read");
    cover property ($rose(mem_wstrobe_n));
    cover property ($rose(mem_oe_n));
    cover property ($rose(mem_ready));
endmodule
bind nvs_host nvs_host_sva nvs_host_sva_i (.core_clk, .srst, .mem_ready, .mem_addr, .mem_sel_n,
    .mem_wstrobe_n, .mem_oe_n, .mem_dq_o, .mem_dq_oe);
`default_nettype wire

// ### dv/nvs_host_tb.sv
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
`default_nettype none
module nvs_host_tb;
    import nvs_pkg::*;
    localparam int LOCK = 50;
    // *****************
    // Harness and tasks
    // *****************
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    logic              req_valid = 1'b0;
    logic              req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic              req_ready, rsp_valid, mem_ready, mem_sel_n, mem_wstrobe_n, mem_oe_n, mem_dq_oe;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] rsp_rdata, mem_dq_o, mem_dout, rd_q;
    wire  logic [DATA_W-1:0] mem_dq_i = mem_dq_oe ? mem_dq_o : mem_dout;
    int                n_errors = 0;
    int                comparisons = 0;
    int                cyc = 0;
    nvs_host #(.LOCKOUT_CYCLES(LOCK)) nvs_host_i (.core_clk, .srst, .req_valid, .req_write, .req_addr,
        .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_ready, .mem_addr, .mem_sel_n,
        .mem_wstrobe_n, .mem_oe_n, .mem_dq_o, .mem_dq_oe, .mem_dq_i);
    nvs_mem_model nvs_mem_model_i (.addr(mem_addr), .sel_n(mem_sel_n), .wstrobe_n(mem_wstrobe_n),
        .oe_n(mem_oe_n), .din(mem_dq_i), .dout(mem_dout));
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held from a falling edge until the rising edge that takes it
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n = 0;
        @(negedge core_clk);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        while (req_ready !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        while (!w && rsp_valid !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        rd_q = rsp_rdata;
        chk("request served", 8'h01, {7'h0, n < 400});
    endtask
    task automatic t_lockout();
        int n = 0;
        chk("ready in lockout", 8'h00, {6'h0, mem_ready, req_ready});
        while (mem_ready !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        chk("lockout length", 8'h01, {7'h0, n >= LOCK - 2 && n <= LOCK + 4});
        $display("test lockout done");
    endtask
    task automatic t_write_read();
        logic [ADDR_W-1:0] a [3] = '{15'h7FFF, 15'h0000, 15'h2AAA};
        logic [DATA_W-1:0] d [3] = '{8'hA5, 8'h5A, 8'hFF};
        for (int i = 0; i < 3; i++) xfer(1'b1, a[i], d[i]);
        xfer(1'b1, a[0], 8'h3C);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, a[i], 8'h00);
            chk("read data", i == 0 ? 8'h3C : d[i], rd_q);
        end
        $display("test write_read done");
    endtask
    task automatic t_reset_mid();
        @(negedge core_clk);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, 1'b1, 15'h1234, 8'h81};
        repeat (20) @(negedge core_clk);
        {srst, req_valid} = 2'b10;
        repeat (2) @(negedge core_clk);
        chk("pins in reset", 8'h06, {5'h0, mem_sel_n, mem_wstrobe_n, mem_dq_oe});
        srst = 1'b0;
        t_lockout();
        $display("test reset_mid done");
    endtask
    initial begin
        repeat (12) @(negedge core_clk);
        srst = 1'b0;
        t_lockout();
        t_write_read();
        t_reset_mid();
        give_verdict();
    end
endmodule
`default_nettype wire
